// >>> common/pmac_defs.svh
// Register offsets, field positions and reset values of the multiply-accumulate block
`ifndef PMAC_DEFS_SVH
`define PMAC_DEFS_SVH

`define PMAC_ADDR_W        8
`define PMAC_OFF_CTRL      8'h00
`define PMAC_OFF_STATUS    8'h04
`define PMAC_OFF_RES_LOW   8'h08
`define PMAC_OFF_RES_GUARD 8'h0C
`define PMAC_OFF_OPERANDS  8'h10

`define PMAC_CTRL_ENABLE   0
`define PMAC_CTRL_CLEAR    1
`define PMAC_CTRL_RESET    1'h1

`define PMAC_STAT_CNT_LSB  0
`define PMAC_STAT_CNT_MSB  15
`define PMAC_STAT_CTL_LSB  16
`define PMAC_STAT_CTL_MSB  19

`define PMAC_OPND_X_LSB    0
`define PMAC_OPND_Y_LSB    16

`define PMAC_GUARD_MSB     34
`define PMAC_GUARD_LSB     32
`define PMAC_HIGH_MSB      31
`define PMAC_HIGH_LSB      16
`define PMAC_LOW_MSB       15
`define PMAC_LOW_LSB       0
`define PMAC_ROUND_BIT     15

`endif

// >>> common/pmac_pkg.sv
// Types shared by the multiply-accumulate block
package pmac_pkg;

  // Control bits captured with the operands
  typedef struct packed {
    logic running_sum_enable;
    logic subtract_select;
    logic twos_complement_select;
    logic round_up_enable;
  } pmac_ctrl_type;

  // Output register split into its three words
  typedef struct packed {
    logic [2:0]  guard_product_bits;
    logic [15:0] high_product_word;
    logic [15:0] low_product_word;
  } pmac_result_type;

endpackage

// >>> logic/pmac_pin_sync.sv
// Two-stage pin synchroniser with rising-edge detection
`timescale 1ns/1ps
module pmac_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
          prev_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      // Rising edge seen on the settled copy only
      assign rise_out[i] = sync_q[i] & ~prev_q[i];
    end
  endgenerate

  assign level_out = sync_q;

endmodule

// >>> logic/pmac_top.sv
// 16x16 multiply-accumulate datapath with pin interface and APB status window
`timescale 1ns/1ps
`include "pmac_defs.svh"

// Summary of operation
// - First operand is captured on each rising edge of its operand clock.
// - Second operand is captured from the shared pins on its clock's rising edge.
// - Shared pins carry second operand in and low product out, one driver at once.
// - Low product word appears on shared pins after the product clock loads it.
// - High product word output updates after each product clock rising edge.
// - Accumulate high adds stored result to product or subtracts it from product; low stores the product alone.
// - Accumulate control is sampled on either operand clock's rising edge.
// - Accumulate with subtract stores product minus stored result at next product edge.
// - Accumulate without subtract stores product plus stored result.
// - Subtract control is registered on either operand clock's rising edge.
// - Subtract control has no effect while accumulate is low.
// - Operands are signed or unsigned per the registered representation control.
// - Multiply-only guard bits hold the product sign, or zero when unsigned.
// - Rounding control rounds high and guard words upward.
// - Accumulated result is rounded back to single precision plus guard bits.
// - Guard, high and low words have separate output disables, synchronised and registered on pclk.
// - Operand registers load only on rising edges of their clocks.
// - Representation high means two's complement, low means unsigned.
// - Rounding adds one at the top bit of the low product word.
// - A word's drivers are off while its disable is high, on while low.
// - Output register is 35 bits: guard 34..32, high 31..16, low 15..0.
module pmac_top
  import pmac_pkg::*;
#(
  parameter int OPND_W = 16,
  parameter int CNT_W  = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PMAC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Operand pins
  input  wire logic [OPND_W-1:0]       first_operand,
  input  wire logic                    first_operand_clock,
  input  wire logic                    second_operand_clock,
  input  wire logic                    product_clock,
  input  wire logic                    running_sum_enable,
  input  wire logic                    subtract_select,
  input  wire logic                    twos_complement_select,
  input  wire logic                    round_up_enable,
  input  wire logic                    guard_out_disable,
  input  wire logic                    high_word_out_disable,
  input  wire logic                    low_word_out_disable,
  // Shared second operand / low product pins
  input  wire logic [OPND_W-1:0]       shared_in,
  output logic      [OPND_W-1:0]       shared_out,
  output logic                         shared_oe,
  // Product outputs
  output logic      [OPND_W-1:0]       high_product_word,
  output logic                         high_word_oe,
  output logic      [2:0]              guard_product_bits,
  output logic                         guard_oe
);

  localparam int PROD_W = 2 * OPND_W + 3;
  localparam int SYNC_W = 2 * OPND_W + 10;

  // Pin synchronisers: all pins pass together so data and clocks stay aligned
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_lvl;
  logic [SYNC_W-1:0] pins_rise;

  assign pins_raw = {first_operand, shared_in,
                     first_operand_clock, second_operand_clock, product_clock,
                     running_sum_enable, subtract_select,
                     twos_complement_select, round_up_enable,
                     guard_out_disable, high_word_out_disable, low_word_out_disable};

  pmac_pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (pins_raw),
    .level_out (pins_lvl),
    .rise_out  (pins_rise)
  );

  logic [OPND_W-1:0] x_pin;
  logic [OPND_W-1:0] y_pin;
  logic              x_rise;
  logic              y_rise;
  logic              p_rise;
  pmac_ctrl_type     ctrl_pin;
  logic              guard_dis;
  logic              high_dis;
  logic              low_dis;

  // Unpack synchronised pins; only rising edges are used as load events
  assign x_pin     = pins_lvl[SYNC_W-1 -: OPND_W];
  assign y_pin     = pins_lvl[SYNC_W-OPND_W-1 -: OPND_W];
  assign x_rise    = pins_rise[9];
  assign y_rise    = pins_rise[8];
  assign p_rise    = pins_rise[7];
  assign ctrl_pin  = pins_lvl[6:3];
  assign guard_dis = pins_lvl[2];
  assign high_dis  = pins_lvl[1];
  assign low_dis   = pins_lvl[0];

  // Software control state
  logic              enable_q;
  logic              clear_q;
  logic [CNT_W-1:0]  load_count_q;

  // Operand and control registers
  logic [OPND_W-1:0] x_q;
  logic [OPND_W-1:0] y_q;
  pmac_ctrl_type     ctrl_q;
  pmac_result_type   result_q;
  pmac_result_type   result_d;

  // First operand register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_q <= 16'h0000;
    end else if (enable_q && x_rise) begin
      x_q <= x_pin;
    end
  end

  // Second operand register, taken from the shared pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_q <= 16'h0000;
    end else if (enable_q && y_rise) begin
      y_q <= y_pin;
    end
  end

  // Controls ride with whichever operand clock rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else if (enable_q && (x_rise || y_rise)) begin
      ctrl_q <= ctrl_pin;
    end
  end

  // Datapath: extend each operand by one bit so signed and unsigned share one multiplier
  logic signed [OPND_W:0]   x_ext;
  logic signed [OPND_W:0]   y_ext;
  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] stored;
  logic signed [PROD_W-1:0] combined;
  logic signed [PROD_W-1:0] round_term;

  always_comb begin
    x_ext = {ctrl_q.twos_complement_select & x_q[OPND_W-1], x_q};
    y_ext = {ctrl_q.twos_complement_select & y_q[OPND_W-1], y_q};
  end

  // Sign-extended product fills guard bits with sign, or zero when unsigned
  // Widen before multiplying so the full product survives in every tool
  assign product = PROD_W'(x_ext) * PROD_W'(y_ext);
  assign stored  = result_q;

  // Accumulate, add or subtract; subtract is ignored without accumulate
  always_comb begin
    if (!ctrl_q.running_sum_enable) begin
      combined = product;
    end else if (ctrl_q.subtract_select) begin
      combined = product - stored;
    end else begin
      combined = product + stored;
    end
  end

  // Rounding adds one at the top of the low word, in both modes
  assign round_term = ctrl_q.round_up_enable ?
                      (PROD_W'(1) <<< `PMAC_ROUND_BIT) : '0;
  assign result_d   = combined + round_term;

  // Output register: product edge wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (enable_q && p_rise) begin
      result_q <= result_d;
    end else if (clear_q) begin
      result_q <= '0;
    end
  end

  // Count product loads for software visibility
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_count_q <= '0;
    end else if (enable_q && p_rise) begin
      load_count_q <= load_count_q + CNT_W'(1);
    end
  end

  // Output words come straight from the result register
  always_comb begin
    shared_out         = result_q.low_product_word;
    high_product_word  = result_q.high_product_word;
    guard_product_bits = result_q.guard_product_bits;
  end

  // Drive enables follow the disable pins, not gated by any clock edge.
  // One flop keeps outputs registered; the pin still has no load semantics.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_oe    <= 1'b0;
      high_word_oe <= 1'b0;
      guard_oe     <= 1'b0;
    end else begin
      shared_oe    <= ~low_dis;
      high_word_oe <= ~high_dis;
      guard_oe     <= ~guard_dis;
    end
  end

  // APB decode: zero wait state, answer prepared in the setup cycle
  logic        setup_phase;
  logic        write_fire;
  logic        addr_ok;
  logic [31:0] read_mux;

  assign setup_phase = psel & ~penable;
  assign write_fire  = psel & penable & pready & pwrite;

  always_comb begin
    addr_ok  = 1'b1;
    read_mux = 32'h0000_0000;
    unique case (paddr)
      `PMAC_OFF_CTRL: begin
        read_mux[`PMAC_CTRL_ENABLE] = enable_q;
      end
      `PMAC_OFF_STATUS: begin
        read_mux[`PMAC_STAT_CNT_MSB:`PMAC_STAT_CNT_LSB] = load_count_q;
        read_mux[`PMAC_STAT_CTL_MSB:`PMAC_STAT_CTL_LSB] = ctrl_q;
      end
      `PMAC_OFF_RES_LOW: begin
        read_mux = result_q[`PMAC_HIGH_MSB:`PMAC_LOW_LSB];
      end
      `PMAC_OFF_RES_GUARD: begin
        read_mux[2:0] = result_q[`PMAC_GUARD_MSB:`PMAC_GUARD_LSB];
      end
      `PMAC_OFF_OPERANDS: begin
        read_mux[`PMAC_OPND_X_LSB +: OPND_W] = x_q;
        read_mux[`PMAC_OPND_Y_LSB +: OPND_W] = y_q;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Bus answer registers: pready rises for exactly the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
      if (setup_phase && !pwrite) begin
        prdata <= read_mux;
      end
    end
  end

  // Control register; clear is a one-cycle pulse from a written one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `PMAC_CTRL_RESET;
      clear_q  <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (write_fire && paddr == `PMAC_OFF_CTRL) begin
        enable_q <= pwdata[`PMAC_CTRL_ENABLE];
        clear_q  <= pwdata[`PMAC_CTRL_CLEAR];
      end
    end
  end

endmodule

// >>> verification/pmac_checker.sv
// Port-level assertions for the multiply-accumulate block
`timescale 1ns/1ps
module pmac_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        product_clock,
  input wire logic        low_word_out_disable,
  input wire logic        high_word_out_disable,
  input wire logic        guard_out_disable,
  input wire logic        shared_oe,
  input wire logic        high_word_oe,
  input wire logic        guard_oe,
  input wire logic [15:0] high_product_word,
  input wire logic [15:0] shared_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  // Six quiet edges flush the pin synchroniser, so no load can still be in flight
  sequence s_quiet;
    (!product_clock && !psel)[*6];
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_idle_quiet: assert property (!psel |=> !pready) else $error("ready without request");
  a_err_unmapped: assert property ((s_setup and paddr > 8'h10) |=> pslverr)
    else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_result_hold: assert property (s_quiet |=> $stable(high_product_word) && $stable(shared_out))
    else $error("result moved without product clock");
  a_low_drive: assert property (!low_word_out_disable[*5] |=> shared_oe)
    else $error("low word not driven");
  a_low_release: assert property (low_word_out_disable[*5] |=> !shared_oe)
    else $error("low word still driven");
  a_high_ctl: assert property (high_word_out_disable[*5] |=> !high_word_oe)
    else $error("high word still driven");
  a_guard_ctl: assert property (guard_out_disable[*5] |=> !guard_oe)
    else $error("guard bits still driven");
endmodule

// >>> verification/pmac_host_model.sv
// Far-side controller model driving operands, controls and clocks onto the pins
`timescale 1ns/1ps
module pmac_host_model
  import pmac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        shared_oe,
  input  wire logic [15:0] shared_out,
  output logic      [15:0] first_operand,
  output logic             first_operand_clock,
  output logic             second_operand_clock,
  output logic             product_clock,
  output logic             running_sum_enable,
  output logic             subtract_select,
  output logic             twos_complement_select,
  output logic             round_up_enable,
  output logic             low_word_out_disable,
  output logic      [15:0] shared_in
);
  logic [15:0]   y_q;
  logic          y_en;
  pmac_ctrl_type ctl;
  // Controls travel as one struct, held until the next operation
  assign {running_sum_enable, subtract_select, twos_complement_select, round_up_enable} = ctl;
  // Released wire shows the inverse so a stale value never passes
  assign shared_in = shared_oe ? shared_out : (y_en ? y_q : ~y_q);
  initial begin
    {first_operand, y_q, y_en, ctl} = '0;
    {first_operand_clock, second_operand_clock, product_clock} = 3'h0;
    low_word_out_disable = 1'b1;
  end
  // One load of both operands, then one product clock
  task automatic mac(input logic [15:0] x, input logic [15:0] y, input pmac_ctrl_type c);
    low_word_out_disable <= 1'b1;
    repeat (6) @(posedge pclk);
    first_operand <= x;
    y_q <= y;
    y_en <= 1'b1;
    ctl <= c;
    repeat (2) @(posedge pclk);
    first_operand_clock <= 1'b1;
    second_operand_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    first_operand <= ~x;
    first_operand_clock <= 1'b0;
    second_operand_clock <= 1'b0;
    repeat (4) @(posedge pclk);
    y_en <= 1'b0;
    product_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    product_clock <= 1'b0;
    low_word_out_disable <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// >>> verification/test_pmac_top.sv
// Self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
module test_pmac_top;
  import pmac_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        guard_out_disable = 1'b0, high_word_out_disable = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, first_operand_clock, second_operand_clock, product_clock;
  logic        running_sum_enable, subtract_select, twos_complement_select, round_up_enable;
  logic        low_word_out_disable, shared_oe, high_word_oe, guard_oe;
  logic [15:0] first_operand, shared_in, shared_out, high_product_word;
  logic [2:0]  guard_product_bits;
  logic [34:0] model = '0;
  int          fail_count = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  pmac_top pmac_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .first_operand, .first_operand_clock, .second_operand_clock,
    .product_clock, .running_sum_enable, .subtract_select, .twos_complement_select,
    .round_up_enable, .guard_out_disable, .high_word_out_disable, .low_word_out_disable,
    .shared_in, .shared_out, .shared_oe, .high_product_word, .high_word_oe,
    .guard_product_bits, .guard_oe);
  pmac_host_model pmac_host_model_inst (.pclk, .shared_oe, .shared_out, .first_operand,
    .first_operand_clock, .second_operand_clock, .product_clock, .running_sum_enable,
    .subtract_select, .twos_complement_select, .round_up_enable, .low_word_out_disable,
    .shared_in);
  task automatic chk(input string name, input logic [34:0] exp, input logic [34:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until ready is seen at a rising edge; one idle edge keeps calls apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Expected result kept as a 35-bit running sum, wrapping like the register
  task automatic op(input logic [15:0] x, input logic [15:0] y, input pmac_ctrl_type c);
    logic [34:0] p;
    p = c.twos_complement_select ? {{19{x[15]}}, x} * {{19{y[15]}}, y} : {19'h0, x} * {19'h0, y};
    model = !c.running_sum_enable ? p : (c.subtract_select ? p - model : p + model);
    if (c.round_up_enable) model = model + 35'h0_0000_8000;
    pmac_host_model_inst.mac(x, y, c);
    chk("result", model, {guard_product_bits, high_product_word, shared_out});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // About 340 cycles of work expected; roughly 35 times that means a hang
  initial begin
    #120000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    op(16'h0003, 16'h0005, 4'h0);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("operands", 35'h0_0005_0003, {3'h0, rd});
    op(16'h0002, 16'h0004, 4'h8);
    op(16'h0001, 16'h0064, 4'hC);
    op(16'hFFFF, 16'h0002, 4'h6);
    op(16'hFFFF, 16'hFFFF, 4'h0);
    op(16'h0100, 16'h0080, 4'h1);
    op(16'h0003, 16'h0003, 4'h9);
    op(16'h8000, 16'h8000, 4'h2);
    op(16'h7FFF, 16'hFFFF, 4'hE);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("status", 35'h0_000E_0009, {3'h0, rd});
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("refused", 35'h0_0000_0001, {34'h0, err});
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("res_low", {3'h0, model[31:0]}, {3'h0, rd});
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("res_guard", {32'h0, model[34:32]}, {3'h0, rd});
    // Disabled block must ignore every pin clock edge
    apb(1'b1, 8'h00, 32'h0000_0000);
    pmac_host_model_inst.mac(16'h0005, 16'h0007, 4'h0);
    chk("disabled", model, {guard_product_bits, high_product_word, shared_out});
    apb(1'b1, 8'h00, 32'h0000_0003);
    model = '0;
    op(16'h0002, 16'h0004, 4'h8);
    guard_out_disable <= 1'b1;
    high_word_out_disable <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("enables", 35'h0_0000_0001, {32'h0, guard_oe, high_word_oe, shared_oe});
    close_out();
  end
endmodule
bind pmac_top pmac_checker pmac_checker_inst (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .product_clock, .low_word_out_disable, .high_word_out_disable, .guard_out_disable,
  .shared_oe, .high_word_oe, .guard_oe, .high_product_word, .shared_out);
